//--- common/wdt_pkg.sv
package wdt_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] CLOCK_CONTROL_ADDR     = 8'h8e;
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR  = 8'hd8;
    localparam logic [7:0] EXT_INT_ENABLE_ADDR    = 8'he8;
    localparam logic [7:0] INT_ENABLE_ADDR        = 8'ha8;
    localparam logic [7:0] POWER_MODE_ADDR        = 8'hc7;
    localparam logic [7:0] IRQ_STATUS_ADDR        = 8'hf1;
    localparam logic [7:0] IRQ_CLEAR_ADDR         = 8'hf2;
    localparam logic [7:0] IRQ_ENABLE_ADDR        = 8'hf3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int WDC_RESTART_BIT        = 0;
    localparam int WDC_RESET_ENABLE_BIT   = 1;
    localparam int WDC_RESET_CAUSE_BIT    = 2;
    localparam int WDC_IRQ_FLAG_BIT       = 3;
    localparam int CKC_SELECT_LO_BIT      = 6;
    localparam int CKC_SELECT_HI_BIT      = 7;
    localparam int EIE_WDT_IRQ_ENABLE_BIT = 4;
    localparam int IE_GLOBAL_ENABLE_BIT   = 7;
    localparam int PMR_MULT_4X_BIT        = 3;
    localparam int PMR_DIVIDE_LO_BIT      = 6;
    localparam int PMR_DIVIDE_HI_BIT      = 7;
    localparam int STAT_TIMEOUT_BIT       = 0;
    localparam int STAT_WDT_RESET_BIT     = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] CLOCK_CONTROL_RESET    = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
    localparam logic [7:0] EXT_INT_ENABLE_RESET   = 8'h00;
    localparam logic [7:0] INT_ENABLE_RESET       = 8'h00;
    localparam logic [7:0] POWER_MODE_RESET       = 8'h40;
    localparam logic [7:0] IRQ_REG_RESET          = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS      = 10;
    localparam int OSC_PERIOD_NS      = 10;
    localparam int EXP_4X             = 15;
    localparam int EXP_2X             = 16;
    localparam int EXP_DIV1           = 17;
    localparam int EXP_DIV1024        = 27;
    localparam int EXP_STEP           = 3;
    localparam int RESET_DELAY_SYSCLK = 512;
    localparam int DELAY_4X_CYCLES    = RESET_DELAY_SYSCLK / 4;
    localparam int DELAY_2X_CYCLES    = RESET_DELAY_SYSCLK / 2;
    localparam int DELAY_DIV1_CYCLES  = RESET_DELAY_SYSCLK;
    localparam int DELAY_DIV1024      = RESET_DELAY_SYSCLK * 1024;
    localparam int RST_PULSE_OSC      = 13;
    localparam int RST_PULSE_CYCLES   = (RST_PULSE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        PH_RUN   = 3'b001,
        PH_DELAY = 3'b010,
        PH_PULSE = 3'b100
    } wdt_phase_type;

endpackage

//--- design/wdt_watchdog_timer_unit.sv
`timescale 1ns/1ps

// Behaviour
// - Time-out sets interrupt flag, control bit 3.
// - CPU irq needs flag, local and global enable.
// - Restart bit restarts count, then self-clears.
// - Early restart begins interval over, no time-out.
// - Enabled reset follows time-out by 512 sysclks.
// - CPU reset only when reset-enable bit set.
// - Watchdog reset lasts 13 oscillator cycles.
// - Reset sets cause flag; only software or rst clears.
// - Counter free-runs, flags every interval regardless.
// - Irq flag cleared only by software or reset.
// - Clock control bits 7:6 select interval.
// - Divide-by-1 time-outs are 2^17..2^26 clocks.
// - Time-out tracks clock mode, step times eight.
// - Interrupt and reset enabled independently.
module wdt_watchdog_timer_unit
    import wdt_pkg::*;
#(
    parameter int TIMEOUT_EXP_4X      = EXP_4X,
    parameter int TIMEOUT_EXP_2X      = EXP_2X,
    parameter int TIMEOUT_EXP_DIV1    = EXP_DIV1,
    parameter int TIMEOUT_EXP_DIV1024 = EXP_DIV1024,
    parameter int TIMEOUT_EXP_STEP    = EXP_STEP,
    parameter int DELAY_DIV1024_CYC   = DELAY_DIV1024,
    parameter int CNT_W               = 37,
    parameter int DLY_W               = 20
)
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] writeData,
    input  wire logic       writeStrobe,
    input  wire logic       readStrobe,
    output logic      [7:0] readData,
    // CPU side
    output logic            cpuReset,
    output logic            cpuWatchdogIrq,
    // Interrupt line
    output logic            irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [DLY_W-1:0] delay;
        logic [4:0]       pulse;
        wdt_phase_type    phase;
        logic [7:0]       clockCtl;
        logic [7:0]       wdCtl;
        logic [7:0]       extIntEn;
        logic [7:0]       intEn;
        logic [7:0]       powerMode;
        logic [7:0]       irqStatus;
        logic [7:0]       irqEnable;
        logic [7:0]       readData;
        logic             resetOut;
    } wdt_regs_type;

    localparam wdt_regs_type REGS_RESET = '{
        count:     '0,
        delay:     '0,
        pulse:     '0,
        phase:     PH_RUN,
        clockCtl:  CLOCK_CONTROL_RESET,
        wdCtl:     WATCHDOG_CONTROL_RESET,
        extIntEn:  EXT_INT_ENABLE_RESET,
        intEn:     INT_ENABLE_RESET,
        powerMode: POWER_MODE_RESET,
        irqStatus: IRQ_REG_RESET,
        irqEnable: IRQ_REG_RESET,
        readData:  8'h00,
        resetOut:  1'b0
    };

    wdt_regs_type state_reg;
    wdt_regs_type state_next;

    // ****************************************************************
    // Clock mode decode
    // ****************************************************************
    logic [5:0]       baseExp;
    logic [5:0]       stepExp;
    logic [5:0]       intervalExp;
    logic [63:0]      intervalFull;
    logic [CNT_W-1:0] terminalCount;
    logic [DLY_W-1:0] delayLast;
    logic [2:0]       modeBits;
    logic [1:0]       intervalSel;

    always_comb
    begin
        modeBits    = {state_reg.powerMode[PMR_MULT_4X_BIT],
                       state_reg.powerMode[PMR_DIVIDE_HI_BIT],
                       state_reg.powerMode[PMR_DIVIDE_LO_BIT]};
        intervalSel = {state_reg.clockCtl[CKC_SELECT_HI_BIT],
                       state_reg.clockCtl[CKC_SELECT_LO_BIT]};
        case (modeBits)
            3'b100:
            begin
                baseExp   = 6'(TIMEOUT_EXP_4X);
                delayLast = DLY_W'(DELAY_4X_CYCLES - 1);
            end
            3'b000:
            begin
                baseExp   = 6'(TIMEOUT_EXP_2X);
                delayLast = DLY_W'(DELAY_2X_CYCLES - 1);
            end
            3'b011,
            3'b111:
            begin
                baseExp   = 6'(TIMEOUT_EXP_DIV1024);
                delayLast = DLY_W'(DELAY_DIV1024_CYC - 1);
            end
            default:
            begin
                baseExp   = 6'(TIMEOUT_EXP_DIV1);
                delayLast = DLY_W'(DELAY_DIV1_CYCLES - 1);
            end
        endcase
        stepExp       = 6'(TIMEOUT_EXP_STEP);
        intervalExp   = 6'(baseExp + 6'(stepExp * 6'(intervalSel)));
        intervalFull  = (64'h1 << intervalExp) - 64'h1;
        terminalCount = intervalFull[CNT_W-1:0];
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic       wrWatchdog;
    logic       restartReq;
    logic       timeout;
    logic       fireReset;
    logic [7:0] clearMask;

    always_comb
    begin
        state_next = state_reg;
        wrWatchdog = writeStrobe && (addr == WATCHDOG_CONTROL_ADDR);
        restartReq = wrWatchdog && writeData[WDC_RESTART_BIT];
        timeout    = 1'b0;
        fireReset  = 1'b0;
        clearMask  = 8'h00;

        // Plain register writes.
        if (writeStrobe)
        begin
            case (addr)
                CLOCK_CONTROL_ADDR:  state_next.clockCtl  = writeData;
                EXT_INT_ENABLE_ADDR: state_next.extIntEn  = writeData;
                INT_ENABLE_ADDR:     state_next.intEn     = writeData;
                POWER_MODE_ADDR:     state_next.powerMode = writeData;
                IRQ_ENABLE_ADDR:     state_next.irqEnable = writeData;
                IRQ_CLEAR_ADDR:      clearMask            = writeData;
                default:             state_next.clockCtl  = state_reg.clockCtl;
            endcase
        end

        // Watchdog control: software may write flags, hardware sets win below.
        state_next.wdCtl[WDC_RESTART_BIT] = 1'b0;
        if (wrWatchdog)
        begin
            state_next.wdCtl = writeData;
        end

        // Free-running counter with restart.
        if (restartReq || state_reg.phase == PH_PULSE)
        begin
            state_next.count = '0;
        end
        else if (state_reg.count >= terminalCount)
        begin
            state_next.count = '0;
            timeout          = 1'b1;
        end
        else
        begin
            state_next.count = state_reg.count + CNT_W'(1);
        end

        if (timeout)
        begin
            state_next.wdCtl[WDC_IRQ_FLAG_BIT] = 1'b1;
        end

        // Reset sequencer.
        case (state_reg.phase)
            PH_RUN:
            begin
                if (timeout)
                begin
                    state_next.phase = PH_DELAY;
                    state_next.delay = '0;
                end
            end
            PH_DELAY:
            begin
                if (restartReq)
                begin
                    state_next.phase = PH_RUN;
                end
                else if (state_reg.delay == delayLast)
                begin
                    if (state_reg.wdCtl[WDC_RESET_ENABLE_BIT])
                    begin
                        fireReset           = 1'b1;
                        state_next.phase    = PH_PULSE;
                        state_next.pulse    = '0;
                        state_next.resetOut = 1'b1;
                    end
                    else
                    begin
                        state_next.phase = PH_RUN;
                    end
                end
                else
                begin
                    state_next.delay = state_reg.delay + DLY_W'(1);
                end
            end
            PH_PULSE:
            begin
                if (state_reg.pulse == 5'(RST_PULSE_CYCLES - 1))
                begin
                    state_next.resetOut = 1'b0;
                    state_next.phase    = PH_RUN;
                end
                else
                begin
                    state_next.pulse = state_reg.pulse + 5'h01;
                end
            end
            default:
            begin
                state_next.phase    = PH_RUN;
                state_next.resetOut = 1'b0;
            end
        endcase

        if (fireReset)
        begin
            state_next.count                      = '0;
            state_next.wdCtl[WDC_RESTART_BIT]     = 1'b0;
            state_next.wdCtl[WDC_IRQ_FLAG_BIT]    = 1'b0;
            state_next.wdCtl[WDC_RESET_CAUSE_BIT] = 1'b1;
        end

        // Sticky status: set wins over clear.
        state_next.irqStatus = state_reg.irqStatus & ~clearMask;
        if (timeout)
        begin
            state_next.irqStatus[STAT_TIMEOUT_BIT] = 1'b1;
        end
        if (fireReset)
        begin
            state_next.irqStatus[STAT_WDT_RESET_BIT] = 1'b1;
        end

        // Read data stands one cycle after the strobe only.
        state_next.readData = 8'h00;
        if (readStrobe)
        begin
            case (addr)
                CLOCK_CONTROL_ADDR:    state_next.readData = state_reg.clockCtl;
                WATCHDOG_CONTROL_ADDR: state_next.readData = state_reg.wdCtl;
                EXT_INT_ENABLE_ADDR:   state_next.readData = state_reg.extIntEn;
                INT_ENABLE_ADDR:       state_next.readData = state_reg.intEn;
                POWER_MODE_ADDR:       state_next.readData = state_reg.powerMode;
                IRQ_STATUS_ADDR:       state_next.readData = state_reg.irqStatus;
                IRQ_ENABLE_ADDR:       state_next.readData = state_reg.irqEnable;
                default:               state_next.readData = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= REGS_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign readData       = state_reg.readData;
    assign cpuReset       = state_reg.resetOut;
    assign cpuWatchdogIrq = state_reg.wdCtl[WDC_IRQ_FLAG_BIT]
                          & state_reg.extIntEn[EIE_WDT_IRQ_ENABLE_BIT]
                          & state_reg.intEn[IE_GLOBAL_ENABLE_BIT];
    assign irq            = |(state_reg.irqStatus & state_reg.irqEnable);

endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import wdt_pkg::*;
;
    localparam int         EXPS[4]  = '{4, 5, 6, 8};
    localparam logic [7:0] MODES[4] = '{8'h08, 8'h00, 8'h40, 8'hc0};
    localparam logic [7:0] RA[9]    = '{8'h8e, 8'hd8, 8'he8, 8'ha8, 8'hc7, 8'hf1, 8'hf2, 8'hf3, 8'h00};
    logic       clock       = 1'b0;
    logic       rst         = 1'b1;
    logic [7:0] addr        = 8'h00;
    logic [7:0] writeData   = 8'h00;
    logic       writeStrobe = 1'b0;
    logic       readStrobe  = 1'b0;
    logic [7:0] readData;
    logic       cpuReset;
    logic       cpuWatchdogIrq;
    logic       irq;
    int         mismatches  = 0;
    int         cmp_count   = 0;
    int         n;
    always #5 clock = ~clock;
    wdt_watchdog_timer_unit #(.TIMEOUT_EXP_4X(EXPS[0]), .TIMEOUT_EXP_2X(EXPS[1]),
        .TIMEOUT_EXP_DIV1(EXPS[2]), .TIMEOUT_EXP_DIV1024(EXPS[3]), .TIMEOUT_EXP_STEP(1),
        .DELAY_DIV1024_CYC(16)) i_wdt_watchdog_timer_unit (.clock(clock), .rst(rst),
        .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData), .cpuReset(cpuReset), .cpuWatchdogIrq(cpuWatchdogIrq), .irq(irq));
    // ****
    // Bus and compare tasks.
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkCount(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        writeStrobe <= 1'b1;
        addr        <= a;
        writeData   <= v;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock);
        readStrobe <= 1'b1;
        addr       <= a;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        chk(readData & m, e);
    endtask
    task automatic pins(input logic [7:0] e);
        #1;
        chk({5'h00, cpuReset, cpuWatchdogIrq, irq}, e);
    endtask
    task automatic cyclesTo(input int which, output int k);
        k = 0;
        #1;
        while (k < 5000 && (which == 0 ? cpuWatchdogIrq : which == 1 ? cpuReset : !cpuReset)
               !== 1'b1)
        begin
            @(posedge clock);
            #1;
            k++;
        end
    endtask
    task automatic regs();
        for (int i = 0; i < 9; i++)
            rdChk(RA[i], 8'hff, RA[i] == POWER_MODE_ADDR ? POWER_MODE_RESET : 8'h00);
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        mismatches++;
        results();
    end
    // ****
    // Test sequence.
    // ****
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        regs();
        wr(IRQ_STATUS_ADDR, 8'hff);
        rdChk(IRQ_STATUS_ADDR, 8'hff, 8'h00);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        rdChk(WATCHDOG_CONTROL_ADDR, 8'h01, 8'h00);
        wr(EXT_INT_ENABLE_ADDR, 8'h10);
        wr(INT_ENABLE_ADDR, 8'h80);
        wr(IRQ_ENABLE_ADDR, 8'h01);
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 4; s++)
            begin
                wr(POWER_MODE_ADDR, MODES[m]);
                wr(CLOCK_CONTROL_ADDR, {s[1:0], 6'h00});
                wr(WATCHDOG_CONTROL_ADDR, 8'h01);
                wr(IRQ_CLEAR_ADDR, 8'h01);
                cyclesTo(0, n);
                chkCount(n, (1 << (EXPS[m] + s)) - 2);
                pins(8'h03);
            end
        wr(EXT_INT_ENABLE_ADDR, 8'h00);
        pins(8'h01);
        wr(EXT_INT_ENABLE_ADDR, 8'h10);
        wr(INT_ENABLE_ADDR, 8'h00);
        pins(8'h01);
        wr(INT_ENABLE_ADDR, 8'h80);
        pins(8'h03);
        rdChk(WATCHDOG_CONTROL_ADDR, 8'h08, 8'h08);
        wr(IRQ_ENABLE_ADDR, 8'h00);
        pins(8'h02);
        wr(IRQ_ENABLE_ADDR, 8'h01);
        wr(IRQ_CLEAR_ADDR, 8'h01);
        pins(8'h02);
        rdChk(IRQ_CLEAR_ADDR, 8'hff, 8'h00);
        wr(WATCHDOG_CONTROL_ADDR, 8'h00);
        pins(8'h00);
        wr(POWER_MODE_ADDR, 8'h40);
        wr(CLOCK_CONTROL_ADDR, 8'h00);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        repeat (50) @(posedge clock);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        cyclesTo(0, n);
        chkCount(n, 64);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        wr(WATCHDOG_CONTROL_ADDR, 8'h02);
        cyclesTo(1, n);
        chkCount(n, 574);
        cyclesTo(2, n);
        chkCount(n, 13);
        rdChk(WATCHDOG_CONTROL_ADDR, 8'h0c, 8'h04);
        rdChk(IRQ_STATUS_ADDR, 8'h02, 8'h02);
        wr(WATCHDOG_CONTROL_ADDR, 8'h00);
        rdChk(WATCHDOG_CONTROL_ADDR, 8'h04, 8'h00);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        wr(WATCHDOG_CONTROL_ADDR, 8'h02);
        cyclesTo(0, n);
        repeat (100) @(posedge clock);
        wr(WATCHDOG_CONTROL_ADDR, 8'h03);
        cyclesTo(1, n);
        chkCount(n, 576);
        cyclesTo(2, n);
        wr(WATCHDOG_CONTROL_ADDR, 8'h00);
        wr(EXT_INT_ENABLE_ADDR, 8'h00);
        wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        cyclesTo(1, n);
        chkCount(n, 5000);
        rdChk(WATCHDOG_CONTROL_ADDR, 8'h08, 8'h08);
        @(posedge clock);
        rst <= 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        regs();
        results();
    end
endmodule

//--- verification/wdt_monitor.sv
`timescale 1ns/1ps
module wdt_monitor
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] writeData,
    input wire logic       writeStrobe,
    input wire logic       readStrobe,
    input wire logic [7:0] readData,
    // Outputs
    input wire logic       cpuReset,
    input wire logic       cpuWatchdogIrq,
    input wire logic       irq
);
    // ****
    // Helper counters.
    // ****
    logic [7:0]  pulseCnt_reg;
    logic [10:0] sinceRst_reg;
    logic [1:0]  seen_reg;
    logic        restartWr;
    assign restartWr = writeStrobe && addr == WATCHDOG_CONTROL_ADDR && writeData[0];
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pulseCnt_reg <= 8'h00;
            sinceRst_reg <= 11'h000;
            seen_reg     <= 2'h0;
        end
        else
        begin
            pulseCnt_reg <= cpuReset ? pulseCnt_reg + 8'h01 : 8'h00;
            sinceRst_reg <= restartWr ? 11'h000 : sinceRst_reg + {10'h000, sinceRst_reg != 11'h7ff};
            seen_reg     <= {seen_reg[0], restartWr};
        end
    end
    // ****
    // Assertions.
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_pulse_length:
        assert property ($fell(cpuReset) |-> pulseCnt_reg == 8'h0d) else $error("pulse length");
    chk_pulse_bound:
        assert property (cpuReset |-> pulseCnt_reg < 8'h0d) else $error("pulse too long");
    chk_restart_gap:
        assert property ($rose(cpuReset) |-> sinceRst_reg > 11'h080) else $error("early reset");
    chk_restart_clears:
        assert property (seen_reg[1] && readStrobe && addr == WATCHDOG_CONTROL_ADDR
            |=> !readData[WDC_RESTART_BIT]) else $error("restart bit stuck");
    chk_local_gate:
        assert property (writeStrobe && addr == EXT_INT_ENABLE_ADDR
            && !writeData[EIE_WDT_IRQ_ENABLE_BIT] |=> !cpuWatchdogIrq) else $error("local gate");
    chk_global_gate:
        assert property (writeStrobe && addr == INT_ENABLE_ADDR
            && !writeData[IE_GLOBAL_ENABLE_BIT] |=> !cpuWatchdogIrq) else $error("global gate");
    chk_irq_mask:
        assert property (writeStrobe && addr == IRQ_ENABLE_ADDR && writeData == 8'h00
            |=> !irq) else $error("irq not masked");
    chk_read_idle:
        assert property (!$past(readStrobe) |-> readData == 8'h00) else $error("read data idle");
    chk_unmapped_read:
        assert property (readStrobe && addr == 8'h00 |=> readData == 8'h00) else $error("unmapped");
    cov_cpu_reset: cover property ($rose(cpuReset));
    cov_wd_irq: cover property ($rose(cpuWatchdogIrq));
    cov_irq: cover property ($rose(irq));
endmodule

bind wdt_watchdog_timer_unit wdt_monitor i_wdt_monitor (.clock(clock), .rst(rst), .addr(addr),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .cpuReset(cpuReset), .cpuWatchdogIrq(cpuWatchdogIrq), .irq(irq));
